/* common/adct_pkg.sv */
// Package: register map, field positions, reset values and conversion timing for the converter sequencer
package adct_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_MASK = 8'h08;
    localparam logic [7:0] OFF_DATA = 8'h0c;

    // ----------------------------------------------------------------
    // Fields
    // ----------------------------------------------------------------
    localparam int CTRL_ON_BIT = 0;
    localparam int CTRL_START_BIT = 1;
    localparam int CTRL_AUTO_BIT = 2;
    localparam int CTRL_FREE_BIT = 3;
    localparam int CTRL_DIV_LSB = 4;
    localparam int DIV_W = 3;
    localparam int ST_DONE_BIT = 0;
    localparam int ST_ABORT_BIT = 1;
    localparam int ST_W = 2;
    localparam int RES_W = 10;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [DIV_W-1:0] DIV_RST = 3'h0;
    localparam logic [ST_W-1:0] MASK_RST = 2'h0;
    localparam logic [ST_W-1:0] STATUS_RST = 2'h0;

    // ----------------------------------------------------------------
    // Timing, in half periods of the converter clock
    // ----------------------------------------------------------------
    localparam int HCNT_W = 6;
    localparam logic [5:0] NORM_END = 6'h1f;   // 15.5 cycles
    localparam logic [5:0] NORM_SH = 6'h07;    // 3.5 cycles
    localparam logic [5:0] FIRST_END = 6'h32;  // 25 cycles
    localparam logic [5:0] FIRST_SH = 6'h1b;   // 13.5 cycles
    localparam logic [5:0] TRIG_SH = 6'h04;    // 2 cycles after the trigger resets the prescaler
    localparam logic [5:0] TRIG_END = TRIG_SH + NORM_END - NORM_SH;
    localparam int SYNC_STAGES = 3;            // CPU cycles of trigger synchronisation
    localparam int PRESC_W = 7;

    typedef enum logic [3:0] {
        ADCT_IDLE = 4'b0001,
        ADCT_ARM = 4'b0010,
        ADCT_CONV = 4'b0100,
        ADCT_HOLD = 4'b1000
    } adct_state_e;

endpackage

/* common/adct_tick_if.sv */
// Interface: converter clock ticks and trigger events between prescaler, synchroniser and sequencer
`timescale 1ns/1ps
interface adct_tick_if;
    logic enable;
    logic clear;
    logic [adct_pkg::DIV_W-1:0] div_sel;
    logic rise;
    logic fall;
    logic trig_event;

    modport presc (input enable, input clear, input div_sel, output rise, output fall);
    modport sync (output trig_event);
    modport seq (output enable, output clear, output div_sel, input rise, input fall, input trig_event);
endinterface

/* core/adct_prescaler.sv */
// Prescaler: divides the CPU clock by a power of two and marks converter clock edges
`timescale 1ns/1ps
module adct_prescaler (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    adct_tick_if.presc tif
);
    logic [adct_pkg::PRESC_W-1:0] cnt_reg, cnt_next;
    logic [adct_pkg::DIV_W-1:0] sel_reg, sel_next;
    logic phase_reg, phase_next;
    logic rise_reg, rise_next;
    logic fall_reg, fall_next;

    // Half period minus one; a select of 7 wraps to all ones, giving 128
    function automatic logic [adct_pkg::PRESC_W-1:0] half_limit(input logic [adct_pkg::DIV_W-1:0] sel);
        half_limit = (7'h1 << sel) - 7'h1;
    endfunction

    // ----------------------------------------------------------------
    // Divider
    // ----------------------------------------------------------------
    always_comb begin
        cnt_next = cnt_reg + 7'h1;
        sel_next = sel_reg;
        phase_next = phase_reg;
        rise_next = 1'b0;
        fall_next = 1'b0;
        if (!tif.enable || tif.clear) begin
            cnt_next = 7'h0;
            phase_next = 1'b0;
            sel_next = tif.div_sel;
        end else if (cnt_reg == half_limit(sel_reg)) begin
            cnt_next = 7'h0;
            phase_next = ~phase_reg;
            rise_next = ~phase_reg;
            fall_next = phase_reg;
            sel_next = tif.div_sel;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_reg <= 7'h0;
            sel_reg <= adct_pkg::DIV_RST;
            phase_reg <= 1'b0;
            rise_reg <= 1'b0;
            fall_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            sel_reg <= sel_next;
            phase_reg <= phase_next;
            rise_reg <= rise_next;
            fall_reg <= fall_next;
        end
    end

    assign tif.rise = rise_reg;
    assign tif.fall = fall_reg;

    off_no_ticks_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        !tif.enable ##1 !tif.enable |-> !(tif.rise || tif.fall))
        else $error("Prescaler ticked while converter off");
endmodule

/* core/adct_trig_sync.sv */
// Trigger synchroniser: three CPU cycles of delay and rising-edge detection
`timescale 1ns/1ps
module adct_trig_sync (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_trigger,
    adct_tick_if.sync tif
);
    logic s1_reg, s2_reg, s3_reg, pulse_reg;
    logic s1_next, s2_next, s3_next, pulse_next;

    // ----------------------------------------------------------------
    // Synchroniser and edge detect
    // ----------------------------------------------------------------
    always_comb begin
        s1_next = i_trigger;
        s2_next = s1_reg;
        s3_next = s2_reg;
        pulse_next = s2_reg & ~s3_reg;
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            pulse_reg <= 1'b0;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
            pulse_reg <= pulse_next;
        end
    end

    assign tif.trig_event = pulse_reg;

    trig_latency_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        tif.trig_event |-> $past(i_trigger, 3) && !$past(i_trigger, 4))
        else $error("Trigger event not three cycles after rising edge");
endmodule

/* core/adct_conv_ctrl.sv */
// Converter sequencer top: APB registers, conversion timing, triggers and interrupt
//
// How it works
// - The CPU clock is divided by the prescaler into the converter clock, ratio from clock_divide_select.
// - The prescaler runs only while converter_on is set and is held cleared while it is low.
// - A software conversion_start begins the conversion at the next converter clock rising edge.
// - A normal conversion lasts 15.5 converter clock cycles.
// - The first conversion after converter_on is set lasts 25 converter clock cycles.
// - Sample-and-hold comes 3.5 cycles into a normal conversion and 13.5 cycles into the first.
// - At completion the result is stored and conversion_done_flag is set together.
// - In single mode conversion_start clears at the same moment as the result is stored.
// - With auto triggering each trigger event that arrives while idle resets the prescaler for a fixed start delay.
// - A triggered sample-and-hold, except in the first conversion, comes two converter cycles after the edge, plus three CPU sync cycles.
// - Free-running mode restarts at once after each completion and leaves conversion_start set.
// - An amplifier change during sampling aborts the conversion, which restarts once it is stable.
// - conversion_start reads as one during every conversion, however started.
`timescale 1ns/1ps
module adct_conv_ctrl (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [adct_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_power_stage_trigger,
    input wire logic i_amp_changed,
    input wire logic i_amp_stable,
    input wire logic [adct_pkg::RES_W-1:0] i_result,
    output logic o_irq,
    output logic o_sample_hold,
    output logic o_busy
);
    adct_tick_if tif ();

    adct_prescaler u_presc (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .tif(tif.presc)
    );

    adct_trig_sync u_sync (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_trigger(i_power_stage_trigger),
        .tif(tif.sync)
    );

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    adct_pkg::adct_state_e state_reg, state_next;
    logic [adct_pkg::HCNT_W-1:0] hcnt_reg, hcnt_next;
    logic converter_on_reg, converter_on_next;
    logic conversion_start_reg, conversion_start_next;
    logic auto_reg, auto_next;
    logic free_reg, free_next;
    logic [adct_pkg::DIV_W-1:0] clock_divide_select_reg, clock_divide_select_next;
    logic first_reg, first_next;
    logic trig_mode_reg, trig_mode_next;
    logic [adct_pkg::ST_W-1:0] status_reg, status_next;
    logic [adct_pkg::ST_W-1:0] mask_reg, mask_next;
    logic [adct_pkg::RES_W-1:0] data_reg, data_next;
    logic irq_reg, irq_next;
    logic sh_reg, sh_next;
    logic busy_reg, busy_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;

    logic commit, wr_ctrl, wr_status, wr_mask, mapped, sw_go, trig_go;
    logic tick, done_evt, abort_evt;
    logic [adct_pkg::HCNT_W-1:0] end_pt, sh_pt, hcnt_inc;
    logic [31:0] rd_mux;

    // ----------------------------------------------------------------
    // APB slave, one wait state so read data comes from a flip-flop
    // ----------------------------------------------------------------
    always_comb begin
        commit = i_psel & i_penable & pready_reg;
        wr_ctrl = commit & i_pwrite & (i_paddr == adct_pkg::OFF_CTRL);
        wr_status = commit & i_pwrite & (i_paddr == adct_pkg::OFF_STATUS);
        wr_mask = commit & i_pwrite & (i_paddr == adct_pkg::OFF_MASK);
        mapped = (i_paddr == adct_pkg::OFF_CTRL) || (i_paddr == adct_pkg::OFF_STATUS)
            || (i_paddr == adct_pkg::OFF_MASK) || (i_paddr == adct_pkg::OFF_DATA);
        rd_mux = 32'h0;
        case (i_paddr)
            adct_pkg::OFF_CTRL: begin
                rd_mux[adct_pkg::CTRL_ON_BIT] = converter_on_reg;
                rd_mux[adct_pkg::CTRL_START_BIT] = conversion_start_reg;
                rd_mux[adct_pkg::CTRL_AUTO_BIT] = auto_reg;
                rd_mux[adct_pkg::CTRL_FREE_BIT] = free_reg;
                rd_mux[adct_pkg::CTRL_DIV_LSB +: adct_pkg::DIV_W] = clock_divide_select_reg;
            end
            adct_pkg::OFF_STATUS: begin
                rd_mux[adct_pkg::ST_W-1:0] = status_reg;
            end
            adct_pkg::OFF_MASK: begin
                rd_mux[adct_pkg::ST_W-1:0] = mask_reg;
            end
            adct_pkg::OFF_DATA: begin
                rd_mux[adct_pkg::RES_W-1:0] = data_reg;
            end
            default: begin
                rd_mux = 32'h0;
            end
        endcase
        pready_next = i_psel & i_penable & ~pready_reg;
        prdata_next = (pready_next & ~i_pwrite) ? rd_mux : 32'h0;
        pslverr_next = pready_next & ~mapped;
    end

    // ----------------------------------------------------------------
    // Conversion sequencer
    // ----------------------------------------------------------------
    always_comb begin
        tick = tif.rise | tif.fall;
        hcnt_inc = hcnt_reg + 6'h01;
        // Trigger timing is counted from the prescaler reset, not from a rising edge
        if (first_reg) begin
            end_pt = adct_pkg::FIRST_END;
            sh_pt = adct_pkg::FIRST_SH;
        end else if (trig_mode_reg) begin
            end_pt = adct_pkg::TRIG_END;
            sh_pt = adct_pkg::TRIG_SH;
        end else begin
            end_pt = adct_pkg::NORM_END;
            sh_pt = adct_pkg::NORM_SH;
        end
        sw_go = wr_ctrl & i_pwdata[adct_pkg::CTRL_START_BIT] & i_pwdata[adct_pkg::CTRL_ON_BIT];
        trig_go = tif.trig_event & auto_reg & converter_on_reg & (state_reg == adct_pkg::ADCT_IDLE);
        abort_evt = (state_reg == adct_pkg::ADCT_CONV) & i_amp_changed & (hcnt_reg < sh_pt);
        done_evt = (state_reg == adct_pkg::ADCT_CONV) & ~abort_evt & tick & (hcnt_inc == end_pt);

        state_next = state_reg;
        hcnt_next = hcnt_reg;
        conversion_start_next = conversion_start_reg;
        trig_mode_next = trig_mode_reg;
        first_next = first_reg;
        data_next = data_reg;
        sh_next = 1'b0;
        tif.clear = 1'b0;
        case (state_reg)
            adct_pkg::ADCT_IDLE: begin
                if (trig_go) begin
                    tif.clear = 1'b1;
                    state_next = adct_pkg::ADCT_CONV;
                    hcnt_next = 6'h00;
                    trig_mode_next = 1'b1;
                    conversion_start_next = 1'b1;
                end else if (sw_go) begin
                    state_next = adct_pkg::ADCT_ARM;
                    trig_mode_next = 1'b0;
                    conversion_start_next = 1'b1;
                end
            end
            adct_pkg::ADCT_ARM: begin
                if (tif.rise) begin
                    state_next = adct_pkg::ADCT_CONV;
                    hcnt_next = 6'h00;
                end
            end
            adct_pkg::ADCT_CONV: begin
                if (abort_evt) begin
                    state_next = adct_pkg::ADCT_HOLD;
                    trig_mode_next = 1'b0;
                end else if (done_evt) begin
                    data_next = i_result;
                    first_next = 1'b0;
                    trig_mode_next = 1'b0;
                    hcnt_next = 6'h00;
                    if (free_reg) begin
                        state_next = adct_pkg::ADCT_CONV;
                    end else begin
                        state_next = adct_pkg::ADCT_IDLE;
                        conversion_start_next = 1'b0;
                    end
                end else if (tick) begin
                    hcnt_next = hcnt_inc;
                    sh_next = (hcnt_inc == sh_pt);
                end
            end
            adct_pkg::ADCT_HOLD: begin
                // Restart goes through the rising-edge wait so the sample phase is whole again
                if (i_amp_stable) begin
                    state_next = adct_pkg::ADCT_ARM;
                end
            end
            default: begin
                state_next = adct_pkg::ADCT_IDLE;
            end
        endcase
        if (!converter_on_reg) begin
            state_next = adct_pkg::ADCT_IDLE;
            hcnt_next = 6'h00;
            conversion_start_next = 1'b0;
            trig_mode_next = 1'b0;
            first_next = 1'b1;
            sh_next = 1'b0;
            if (sw_go) begin
                state_next = adct_pkg::ADCT_ARM;
                conversion_start_next = 1'b1;
            end
        end
        busy_next = (state_next != adct_pkg::ADCT_IDLE);
    end

    // ----------------------------------------------------------------
    // Control, status and interrupt
    // ----------------------------------------------------------------
    always_comb begin
        converter_on_next = converter_on_reg;
        auto_next = auto_reg;
        free_next = free_reg;
        clock_divide_select_next = clock_divide_select_reg;
        mask_next = mask_reg;
        if (wr_ctrl) begin
            converter_on_next = i_pwdata[adct_pkg::CTRL_ON_BIT];
            auto_next = i_pwdata[adct_pkg::CTRL_AUTO_BIT];
            free_next = i_pwdata[adct_pkg::CTRL_FREE_BIT];
            clock_divide_select_next = i_pwdata[adct_pkg::CTRL_DIV_LSB +: adct_pkg::DIV_W];
        end
        if (wr_mask) begin
            mask_next = i_pwdata[adct_pkg::ST_W-1:0];
        end
        // Set wins over a write-one clear in the same cycle
        status_next = status_reg & ~(wr_status ? i_pwdata[adct_pkg::ST_W-1:0] : 2'h0);
        status_next[adct_pkg::ST_DONE_BIT] = status_next[adct_pkg::ST_DONE_BIT] | done_evt;
        status_next[adct_pkg::ST_ABORT_BIT] = status_next[adct_pkg::ST_ABORT_BIT] | abort_evt;
        irq_next = |(status_next & mask_next);
        tif.enable = converter_on_reg;
        tif.div_sel = clock_divide_select_reg;
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_reg <= adct_pkg::ADCT_IDLE;
            hcnt_reg <= 6'h00;
            converter_on_reg <= 1'b0;
            conversion_start_reg <= 1'b0;
            auto_reg <= 1'b0;
            free_reg <= 1'b0;
            clock_divide_select_reg <= adct_pkg::DIV_RST;
            first_reg <= 1'b1;
            trig_mode_reg <= 1'b0;
            status_reg <= adct_pkg::STATUS_RST;
            mask_reg <= adct_pkg::MASK_RST;
            data_reg <= 10'h000;
            irq_reg <= 1'b0;
            sh_reg <= 1'b0;
            busy_reg <= 1'b0;
            prdata_reg <= 32'h0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            hcnt_reg <= hcnt_next;
            converter_on_reg <= converter_on_next;
            conversion_start_reg <= conversion_start_next;
            auto_reg <= auto_next;
            free_reg <= free_next;
            clock_divide_select_reg <= clock_divide_select_next;
            first_reg <= first_next;
            trig_mode_reg <= trig_mode_next;
            status_reg <= status_next;
            mask_reg <= mask_next;
            data_reg <= data_next;
            irq_reg <= irq_next;
            sh_reg <= sh_next;
            busy_reg <= busy_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign o_prdata = prdata_reg;
    assign o_pready = pready_reg;
    assign o_pslverr = pslverr_reg;
    assign o_irq = irq_reg;
    assign o_sample_hold = sh_reg;
    assign o_busy = busy_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);

    done_sets_flag_a: assert property (done_evt |=> status_reg[adct_pkg::ST_DONE_BIT]
        && data_reg == $past(i_result))
        else $error("Completion did not store result and set done flag");
    single_clears_start_a: assert property (done_evt && !free_reg |=> !conversion_start_reg && !busy_reg)
        else $error("Single conversion left start bit set");
    free_restart_a: assert property (done_evt && free_reg |=> conversion_start_reg
        && state_reg == adct_pkg::ADCT_CONV && hcnt_reg == 6'h00)
        else $error("Free-running mode did not restart");
    start_during_conv_a: assert property (state_reg != adct_pkg::ADCT_IDLE |-> conversion_start_reg)
        else $error("Start bit low during conversion");
    first_length_a: assert property (done_evt && first_reg |-> hcnt_reg == adct_pkg::FIRST_END - 6'h01)
        else $error("First conversion length wrong");
    normal_length_a: assert property (done_evt && !first_reg && !trig_mode_reg
        |-> hcnt_reg == adct_pkg::NORM_END - 6'h01)
        else $error("Normal conversion length wrong");
    sample_point_a: assert property (sh_reg && !trig_mode_reg |-> hcnt_reg == (first_reg ?
        adct_pkg::FIRST_SH : adct_pkg::NORM_SH))
        else $error("Sample-and-hold at wrong point");
    trig_resets_presc_a: assert property (trig_go |-> tif.clear ##1 (state_reg == adct_pkg::ADCT_CONV
        && !tif.rise && !tif.fall))
        else $error("Trigger did not reset prescaler");
    abort_hold_a: assert property (abort_evt && converter_on_reg |=> state_reg == adct_pkg::ADCT_HOLD
        ##0 !sh_reg)
        else $error("Amplifier change did not abort");
    arm_on_rise_a: assert property (state_reg == adct_pkg::ADCT_ARM && tif.rise && converter_on_reg
        |=> state_reg == adct_pkg::ADCT_CONV && hcnt_reg == 6'h00)
        else $error("Conversion did not start on rising edge");

    first_done_c: cover property (done_evt && first_reg);
    free_run_c: cover property (done_evt && free_reg);
    abort_c: cover property (abort_evt ##[1:200] state_reg == adct_pkg::ADCT_ARM);
    trig_conv_c: cover property (trig_go ##[1:1000] done_evt);
endmodule

/* verification/test_adct_conv_ctrl.sv */
// Testbench: APB-driven checks of converter sequencing, timing, flags and interrupt
`timescale 1ns/1ps
module test_adct_conv_ctrl;
    logic i_core_clk = 1'b0, i_nrst = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic i_power_stage_trigger = 1'b0, i_amp_changed = 1'b0, i_amp_stable = 1'b1;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0;
    logic [9:0] i_result = 10'h2a5;
    logic [31:0] o_prdata, rd;
    logic o_pready, o_pslverr, o_irq, o_sample_hold, o_busy, err;
    int errors = 0, n_tests = 0;
    adct_conv_ctrl dut (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .i_power_stage_trigger(i_power_stage_trigger), .i_amp_changed(i_amp_changed),
        .i_amp_stable(i_amp_stable), .i_result(i_result), .o_irq(o_irq), .o_sample_hold(o_sample_hold),
        .o_busy(o_busy));
    initial begin
        forever #25 i_core_clk = ~i_core_clk;
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task complete_run;
        if (errors == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s got %h want %h", $time, m, got, exp);
        end
    endtask
    task hang(input string m);
        errors++;
        $display("BAD %0t %s", $time, m);
        complete_run();
    endtask
    // Request held until the edge that samples pready high; read data is taken at that same edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge i_core_clk);
        i_psel <= 1'b1; i_pwrite <= w; i_paddr <= a; i_pwdata <= d;
        @(posedge i_core_clk);
        i_penable <= 1'b1;
        k = 0;
        do begin @(posedge i_core_clk); k++; end while (o_pready !== 1'b1 && k < 20);
        if (o_pready !== 1'b1) hang("no pready");
        rd = o_prdata; err = o_pslverr;
        i_psel <= 1'b0; i_penable <= 1'b0;
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] exp, input string m);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, m);
    endtask
    task wait_sh;
        int k;
        k = 0;
        do begin @(negedge i_core_clk); k++; end while (o_sample_hold !== 1'b1 && k < 3000);
        if (o_sample_hold !== 1'b1) hang("no sample-hold");
    endtask
    // Cycles from the sample-hold pulse to completion; both are fixed half-period counts
    task measure(input int exp, input string m);
        int n;
        wait_sh();
        n = 0;
        do begin @(negedge i_core_clk); n++; end while (o_busy !== 1'b0 && n < 3000);
        if (o_busy !== 1'b0) hang("no completion");
        chk(n, exp, m);
    endtask
    task trig;
        @(posedge i_core_clk) i_power_stage_trigger <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        i_power_stage_trigger <= 1'b0;
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        for (int i = 0; i < 4; i++) rdchk(8'(i * 4), 32'h0, "reset value");
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped error");
        // First conversion at ratio 2: end minus sample-hold is 23 half periods
        apb(1'b1, adct_pkg::OFF_CTRL, 32'h3);
        rdchk(adct_pkg::OFF_CTRL, 32'h3, "start reads one while busy");
        measure(23, "first conversion timing");
        rdchk(adct_pkg::OFF_CTRL, 32'h1, "start cleared");
        rdchk(adct_pkg::OFF_DATA, 32'h2a5, "result");
        rdchk(adct_pkg::OFF_STATUS, 32'h1, "done flag");
        i_result <= 10'h15a;
        apb(1'b1, adct_pkg::OFF_MASK, 32'h1);
        @(negedge i_core_clk);
        chk({31'h0, o_irq}, 32'h1, "irq raised");
        apb(1'b1, adct_pkg::OFF_STATUS, 32'h1);
        @(negedge i_core_clk);
        chk({31'h0, o_irq}, 32'h0, "irq cleared");
        // Ratio 16 keeps the converter clock inside the full-resolution range: 24 half periods of 8 cycles
        apb(1'b1, adct_pkg::OFF_CTRL, 32'h33);
        measure(192, "normal conversion timing");
        rdchk(adct_pkg::OFF_DATA, 32'h15a, "second result");
        // Abort while sampling, restart once stable; held long enough for the ratio change and the arm wait
        apb(1'b1, adct_pkg::OFF_CTRL, 32'h3);
        i_amp_stable <= 1'b0; i_amp_changed <= 1'b1;
        repeat (16) @(posedge i_core_clk);
        i_amp_changed <= 1'b0;
        rdchk(adct_pkg::OFF_STATUS, 32'h3, "abort flagged");
        i_amp_stable <= 1'b1;
        measure(24, "restarted conversion");
        // Free-running keeps start set across completions
        apb(1'b1, adct_pkg::OFF_CTRL, 32'hb);
        repeat (2) wait_sh();
        rdchk(adct_pkg::OFF_CTRL, 32'hb, "free start stays set");
        apb(1'b1, adct_pkg::OFF_CTRL, 32'h0);
        // Busy falls one cycle after the converter bit is seen low
        repeat (2) @(negedge i_core_clk);
        chk({31'h0, o_busy}, 32'h0, "off stops");
        // Triggered: first after switch-on keeps first timing, then normal triggered timing
        apb(1'b1, adct_pkg::OFF_CTRL, 32'h5);
        trig();
        measure(23, "first triggered");
        trig();
        measure(24, "triggered timing");
        complete_run();
    end
endmodule
